// ---- logic/display_cmd_consts.vh ----
/*
  Constants for the display command decoder: command codes, field
  positions, software-reset defaults and timing figures.
  Assumes inclusion by bare name from the design files under logic/.
*/
`ifndef DISPLAY_CMD_CONSTS_VH
`define DISPLAY_CMD_CONSTS_VH

// command codes
`define CMD_IDLE_COMMAND       8'h00
`define CMD_SOFT_RESTART       8'h01
`define CMD_IDENTITY_TRIPLE    8'h04
`define CMD_LINK_ERROR_READ    8'h05
`define CMD_FULL_STATUS        8'h09
`define CMD_POWER_STATE        8'h0a
`define CMD_SCAN_ORDER_READ    8'h0b
`define CMD_PIXEL_FORMAT_READ  8'h0c
`define CMD_IMAGE_STATE        8'h0d
`define CMD_SIGNAL_STATE       8'h0e
`define CMD_DIAGNOSTIC         8'h0f
`define CMD_ENTER_SLEEP        8'h10
`define CMD_LEAVE_SLEEP        8'h11
`define CMD_POLARITY_OFF       8'h20
`define CMD_POLARITY_ON        8'h21
`define CMD_PANEL_OFF          8'h28
`define CMD_PANEL_ON           8'h29
`define CMD_PIXEL_WRITE_START  8'h2c
`define CMD_TEAR_DISABLE       8'h34
`define CMD_TEAR_ENABLE        8'h35
`define CMD_SCAN_ORDER_CONTROL 8'h36
`define CMD_REDUCED_OFF        8'h38
`define CMD_REDUCED_ON         8'h39
`define CMD_PIXEL_FORMAT_SEL   8'h3a
`define CMD_PIXEL_WRITE_CONT   8'h3c
`define CMD_TEAR_LINE_WRITE    8'h44
`define CMD_SCAN_LINE_READ     8'h45
`define CMD_TWO_COLOUR_WRITE   8'h90
`define CMD_TWO_COLOUR_READ    8'h91
`define CMD_FIRST_SUM          8'haa
`define CMD_CONTINUED_SUM      8'haf
`define CMD_MAKER_CODE         8'hda
`define CMD_VERSION_CODE       8'hdb
`define CMD_DRIVER_CODE        8'hdc

// parameter counts and read lengths
`define PARAMS_ONE             3'h1
`define PARAMS_TWO             3'h2
`define READS_ONE              3'h1
`define READS_TWO              3'h2
`define READS_THREE            3'h3
`define READS_FOUR             3'h4
`define IDX_FIRST              3'h0
`define IDX_SECOND             3'h1
`define IDX_THIRD              3'h2
`define IDX_FOURTH             3'h3

// software-reset defaults and the full link error count
`define DEF_PIXEL_FORMAT       3'h6
`define DEF_IDLE_COLOUR        3'h7
`define DEF_SCAN_ORDER         3'h0
`define DEF_TEAR_LINE          9'h000
`define DEF_LINK_ERRORS        7'h00
`define LINK_ERRORS_FULL       7'h7f

// field positions in parameter bytes
`define FLD_ORDER_HI           4
`define FLD_ORDER_LO           2
`define FLD_FORMAT_HI          2
`define FLD_LINE_MSB           0
`define FLD_TEAR_MODE          0

`define BYTE_ZERO              8'h00

// timing
`define MCLK_PERIOD_NS         8
`define NS_PER_MS              1000000
`define RESTART_WAIT_MS        5
`define RESTART_CNT_W          20

`endif

// ---- logic/display_command_decoder.v ----
/*
  Command decoder and status readback of a display controller.
  Host writes command bytes (select low) and parameter or pixel bytes
  (select high) on the rising edge of the write strobe, and reads reply
  bytes while the read strobe is low. All host pins are synchronous.
*/
`timescale 1ns/100ps
`include "display_cmd_consts.vh"
module display_command_decoder
#(
  parameter [`RESTART_CNT_W-1:0] RESTART_CYCLES =
    `RESTART_WAIT_MS * `NS_PER_MS / `MCLK_PERIOD_NS,
  parameter [7:0] MAKER_CODE = 8'h5a,   // arbitrary value
  parameter [7:0] VERSION_CODE = 8'h01, // arbitrary value
  parameter [7:0] DRIVER_CODE = 8'h3c   // arbitrary value
)
(
  input wire mclk_in,
  input wire rst_b_in,
  input wire data_command_select_in,
  input wire write_strobe_b_in,
  input wire read_strobe_b_in,
  input wire [7:0] data_in,
  output reg [7:0] data_out,
  output reg data_oe_out,
  input wire link_error_in,
  input wire hsync_active_in,
  input wire vsync_active_in,
  input wire pixclk_active_in,
  input wire data_enable_active_in,
  input wire register_load_result_in,
  input wire function_check_result_in,
  input wire checksum_compare_result_in,
  input wire [7:0] first_sum_in,
  input wire [7:0] continued_sum_in,
  input wire [8:0] scan_line_in,
  output reg awake_out,
  output reg panel_on_out,
  output reg polarity_flip_out,
  output reg reduced_colour_out,
  output reg tear_enable_out,
  output reg tear_mode_out,
  output reg [8:0] tear_line_out,
  output reg [2:0] scan_order_out,
  output reg [2:0] pixel_format_out,
  output reg [2:0] idle_colour_out,
  output reg [7:0] pixel_data_out,
  output reg pixel_valid_out,
  output reg pixel_first_out,
  output wire restart_busy_out
);
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_PARAM = 5'b00010;
  localparam [4:0] ST_READ = 5'b00100;
  localparam [4:0] ST_PIXEL = 5'b01000;
  localparam [4:0] ST_HOLD = 5'b10000;

  reg [4:0] state_r;
  reg [4:0] state_nxt;
  reg [7:0] cmd_r;
  reg [2:0] idx_r;
  reg [2:0] limit_r;
  reg pixel_new_r;
  reg [6:0] err_count_r;
  reg err_over_r;
  reg [7:0] reply_byte;
  reg [2:0] limit_nxt;
  reg [4:0] cmd_state;
  wire wr_rise;
  wire rd_rise;
  wire rd_fall;
  wire restart_go;
  wire cmd_take;
  wire param_take;
  wire err_clear;

  strobe_edge wr_edge
  (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .level_in(write_strobe_b_in),
    .rise_out(wr_rise),
    .fall_out()
  );

  strobe_edge rd_edge
  (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .level_in(read_strobe_b_in),
    .rise_out(rd_rise),
    .fall_out(rd_fall)
  );

  restart_timer #(.CYCLES(RESTART_CYCLES)) reload_timer
  (
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .start_in(restart_go),
    .busy_out(restart_busy_out)
  );

  // commands are ignored during the reload interval
  assign cmd_take = wr_rise & ~data_command_select_in & ~restart_busy_out;
  assign param_take = wr_rise & data_command_select_in;
  assign restart_go = cmd_take & (data_in == `CMD_SOFT_RESTART);
  assign err_clear = rd_rise & (state_r == ST_READ) &
    (cmd_r == `CMD_LINK_ERROR_READ) & (idx_r == `IDX_FIRST);

  // what a freshly taken command leads to, and how many bytes it owns
  always @*
  begin
    cmd_state = ST_IDLE;
    limit_nxt = 3'h0;
    case (data_in)
      `CMD_TEAR_ENABLE, `CMD_SCAN_ORDER_CONTROL, `CMD_PIXEL_FORMAT_SEL,
      `CMD_TWO_COLOUR_WRITE:
      begin
        cmd_state = ST_PARAM;
        limit_nxt = `PARAMS_ONE;
      end
      `CMD_TEAR_LINE_WRITE:
      begin
        cmd_state = ST_PARAM;
        limit_nxt = `PARAMS_TWO;
      end
      `CMD_PIXEL_WRITE_START, `CMD_PIXEL_WRITE_CONT:
        cmd_state = ST_PIXEL;
      `CMD_IDENTITY_TRIPLE:
      begin
        cmd_state = ST_READ;
        limit_nxt = `READS_THREE;
      end
      `CMD_FULL_STATUS:
      begin
        cmd_state = ST_READ;
        limit_nxt = `READS_FOUR;
      end
      `CMD_SCAN_LINE_READ:
      begin
        cmd_state = ST_READ;
        limit_nxt = `READS_TWO;
      end
      `CMD_LINK_ERROR_READ, `CMD_POWER_STATE, `CMD_SCAN_ORDER_READ,
      `CMD_PIXEL_FORMAT_READ, `CMD_IMAGE_STATE, `CMD_SIGNAL_STATE,
      `CMD_DIAGNOSTIC, `CMD_TWO_COLOUR_READ, `CMD_FIRST_SUM,
      `CMD_CONTINUED_SUM, `CMD_MAKER_CODE, `CMD_VERSION_CODE,
      `CMD_DRIVER_CODE:
      begin
        cmd_state = ST_READ;
        limit_nxt = `READS_ONE;
      end
      default:
        cmd_state = ST_IDLE;
    endcase
  end

  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE, ST_PARAM, ST_READ, ST_PIXEL, ST_HOLD:
      begin
        if (restart_go)
          state_nxt = ST_HOLD;
        else if (cmd_take)
          state_nxt = cmd_state;
        else if (state_r == ST_HOLD && !restart_busy_out)
          state_nxt = ST_IDLE;
        else
          state_nxt = state_r;
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // reply byte for the current read position
  always @*
  begin
    reply_byte = `BYTE_ZERO;
    case (cmd_r)
      `CMD_IDENTITY_TRIPLE:
        case (idx_r)
          `IDX_FIRST: reply_byte = MAKER_CODE;
          `IDX_SECOND: reply_byte = VERSION_CODE;
          `IDX_THIRD: reply_byte = DRIVER_CODE;
          default: reply_byte = `BYTE_ZERO;
        endcase
      `CMD_MAKER_CODE: reply_byte = MAKER_CODE;
      `CMD_VERSION_CODE: reply_byte = VERSION_CODE;
      `CMD_DRIVER_CODE: reply_byte = DRIVER_CODE;
      `CMD_LINK_ERROR_READ: reply_byte = {err_over_r, err_count_r};
      `CMD_FULL_STATUS:
        case (idx_r)
          `IDX_FIRST: reply_byte = {awake_out, 3'h0, scan_order_out, 1'b0};
          `IDX_SECOND: reply_byte = {1'b0, pixel_format_out, reduced_colour_out, 1'b0,
            awake_out, 1'b0};
          `IDX_THIRD: reply_byte = {2'h0, polarity_flip_out, 2'h0, panel_on_out,
            tear_enable_out, 1'b0};
          `IDX_FOURTH: reply_byte = {2'h0, tear_mode_out, 5'h00};
          default: reply_byte = `BYTE_ZERO;
        endcase
      `CMD_POWER_STATE:
        reply_byte = {awake_out, reduced_colour_out, 1'b0, awake_out, 1'b0,
          panel_on_out, 2'h0};
      `CMD_SCAN_ORDER_READ: reply_byte = {3'h0, scan_order_out, 2'h0};
      `CMD_PIXEL_FORMAT_READ: reply_byte = {5'h00, pixel_format_out};
      `CMD_IMAGE_STATE: reply_byte = {2'h0, polarity_flip_out, 5'h00};
      `CMD_SIGNAL_STATE:
        reply_byte = {tear_enable_out, tear_mode_out, hsync_active_in,
          vsync_active_in, pixclk_active_in, data_enable_active_in, 1'b0,
          err_over_r | (err_count_r != `DEF_LINK_ERRORS)};
      `CMD_DIAGNOSTIC:
        reply_byte = {register_load_result_in, function_check_result_in, 5'h00,
          checksum_compare_result_in};
      `CMD_SCAN_LINE_READ:
        case (idx_r)
          `IDX_FIRST: reply_byte = {7'h00, scan_line_in[8]};
          `IDX_SECOND: reply_byte = scan_line_in[7:0];
          default: reply_byte = `BYTE_ZERO;
        endcase
      `CMD_TWO_COLOUR_READ: reply_byte = {5'h00, idle_colour_out};
      `CMD_FIRST_SUM: reply_byte = first_sum_in;
      `CMD_CONTINUED_SUM: reply_byte = continued_sum_in;
      default: reply_byte = `BYTE_ZERO;
    endcase
  end

  // sequencing of command, parameter and read bytes
  always @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state_r <= ST_IDLE;
      cmd_r <= `CMD_IDLE_COMMAND;
      idx_r <= 3'h0;
      limit_r <= 3'h0;
      pixel_new_r <= 1'b0;
      data_out <= `BYTE_ZERO;
      data_oe_out <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      if (cmd_take)
      begin
        cmd_r <= data_in;
        idx_r <= 3'h0;
        limit_r <= limit_nxt;
        pixel_new_r <= (data_in == `CMD_PIXEL_WRITE_START);
      end
      else if (state_r == ST_PARAM && param_take && idx_r < limit_r)
        idx_r <= idx_r + 1'b1;
      else if (state_r == ST_PIXEL && param_take)
        pixel_new_r <= 1'b0;
      else if (state_r == ST_READ && rd_rise && idx_r < limit_r)
        idx_r <= idx_r + 1'b1;
      if (state_r == ST_READ && rd_fall)
      begin
        data_out <= (idx_r < limit_r) ? reply_byte : `BYTE_ZERO;
        data_oe_out <= 1'b1;
      end
      else if (rd_rise || state_r != ST_READ)
        data_oe_out <= 1'b0;
    end
  end

  // settings; a soft reset restores them (pixel contents lie elsewhere)
  always @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      awake_out <= 1'b0;
      panel_on_out <= 1'b0;
      polarity_flip_out <= 1'b0;
      reduced_colour_out <= 1'b0;
      tear_enable_out <= 1'b0;
      tear_mode_out <= 1'b0;
      tear_line_out <= `DEF_TEAR_LINE;
      scan_order_out <= `DEF_SCAN_ORDER;
      pixel_format_out <= `DEF_PIXEL_FORMAT;
      idle_colour_out <= `DEF_IDLE_COLOUR;
    end
    else if (restart_go)
    begin
      panel_on_out <= 1'b0;
      awake_out <= 1'b0;
      polarity_flip_out <= 1'b0;
      reduced_colour_out <= 1'b0;
      tear_enable_out <= 1'b0;
      tear_mode_out <= 1'b0;
      tear_line_out <= `DEF_TEAR_LINE;
      scan_order_out <= `DEF_SCAN_ORDER;
      pixel_format_out <= `DEF_PIXEL_FORMAT;
      idle_colour_out <= `DEF_IDLE_COLOUR;
    end
    else if (cmd_take)
    begin
      case (data_in)
        `CMD_ENTER_SLEEP: awake_out <= 1'b0;
        `CMD_LEAVE_SLEEP: awake_out <= 1'b1;
        `CMD_POLARITY_OFF: polarity_flip_out <= 1'b0;
        `CMD_POLARITY_ON: polarity_flip_out <= 1'b1;
        `CMD_PANEL_OFF: panel_on_out <= 1'b0;
        `CMD_PANEL_ON: panel_on_out <= 1'b1;
        `CMD_TEAR_DISABLE: tear_enable_out <= 1'b0;
        `CMD_TEAR_ENABLE: tear_enable_out <= 1'b1;
        `CMD_REDUCED_OFF: reduced_colour_out <= 1'b0;
        `CMD_REDUCED_ON: reduced_colour_out <= 1'b1;
        default: tear_mode_out <= tear_mode_out;
      endcase
    end
    else if (state_r == ST_PARAM && param_take && idx_r < limit_r)
    begin
      case (cmd_r)
        `CMD_TEAR_ENABLE: tear_mode_out <= data_in[`FLD_TEAR_MODE];
        `CMD_SCAN_ORDER_CONTROL:
          scan_order_out <= data_in[`FLD_ORDER_HI:`FLD_ORDER_LO];
        `CMD_PIXEL_FORMAT_SEL:
          pixel_format_out <= data_in[`FLD_FORMAT_HI:0];
        `CMD_TWO_COLOUR_WRITE: idle_colour_out <= data_in[`FLD_FORMAT_HI:0];
        `CMD_TEAR_LINE_WRITE:
          if (idx_r == `IDX_FIRST)
            tear_line_out[8] <= data_in[`FLD_LINE_MSB];
          else
            tear_line_out[7:0] <= data_in;
        default: tear_mode_out <= tear_mode_out;
      endcase
    end
  end

  // pixel stream out
  always @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pixel_data_out <= `BYTE_ZERO;
      pixel_valid_out <= 1'b0;
      pixel_first_out <= 1'b0;
    end
    else
    begin
      pixel_valid_out <= (state_r == ST_PIXEL) & param_take;
      if (state_r == ST_PIXEL && param_take)
      begin
        pixel_data_out <= data_in;
        pixel_first_out <= pixel_new_r;
      end
    end
  end

  // link error counter; a new error in the read-clear cycle is counted after the clear
  always @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      err_count_r <= `DEF_LINK_ERRORS;
      err_over_r <= 1'b0;
    end
    else if (restart_go)
    begin
      err_count_r <= `DEF_LINK_ERRORS;
      err_over_r <= 1'b0;
    end
    else if (link_error_in)
    begin
      if (err_clear)
        err_count_r <= `DEF_LINK_ERRORS + 1'b1;
      else if (err_count_r == `LINK_ERRORS_FULL)
        err_over_r <= 1'b1;
      else
        err_count_r <= err_count_r + 1'b1;
      if (err_clear)
        err_over_r <= 1'b0;
    end
    else if (err_clear)
    begin
      err_count_r <= `DEF_LINK_ERRORS;
      err_over_r <= 1'b0;
    end
  end
endmodule // display_command_decoder

// ---- logic/restart_timer.v ----
/*
  Busy timer for the software-reset reload interval.
  Assumes start_in is a one-cycle pulse; a start while busy restarts it.
*/
`timescale 1ns/100ps
`include "display_cmd_consts.vh"
module restart_timer
#(
  parameter [`RESTART_CNT_W-1:0] CYCLES = 20'd625000
)
(
  input wire mclk_in,
  input wire rst_b_in,
  input wire start_in,
  output reg busy_out
);
  reg [`RESTART_CNT_W-1:0] count_r;

  always @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      count_r <= {`RESTART_CNT_W{1'b0}};
      busy_out <= 1'b0;
    end
    else if (start_in)
    begin
      count_r <= CYCLES - 1'b1;
      busy_out <= 1'b1;
    end
    else if (count_r != {`RESTART_CNT_W{1'b0}})
      count_r <= count_r - 1'b1;
    else
      busy_out <= 1'b0;
  end
endmodule // restart_timer

// ---- logic/strobe_edge.v ----
/*
  Edge finder for one host strobe level.
  Assumes the strobe is synchronous to mclk_in.
*/
`timescale 1ns/100ps
module strobe_edge
(
  input wire mclk_in,
  input wire rst_b_in,
  input wire level_in,
  output wire rise_out,
  output wire fall_out
);
  reg prev_r;

  // strobes idle high
  always @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      prev_r <= 1'b1;
    else
      prev_r <= level_in;
  end

  assign rise_out = level_in & ~prev_r;
  assign fall_out = ~level_in & prev_r;
endmodule // strobe_edge

// ---- tb/display_cmd_checker_assertions.sv ----
/*
  Concurrent checks on the decoder's top-level ports.
  Assumes host pins synchronous to mclk_in.
*/
`timescale 1ns/100ps
module display_cmd_checker
(
  input wire mclk_in,
  input wire rst_b_in,
  input wire data_command_select_in,
  input wire write_strobe_b_in,
  input wire read_strobe_b_in,
  input wire [7:0] data_in,
  input wire data_oe_out,
  input wire [7:0] pixel_data_out,
  input wire pixel_valid_out,
  input wire panel_on_out,
  input wire awake_out,
  input wire restart_busy_out,
  input wire [2:0] pixel_format_out,
  input wire [2:0] idle_colour_out
);
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (!rst_b_in);
  wire cmd_w = !data_command_select_in && !restart_busy_out;
  a_oe_on_read: assert property ($fell(read_strobe_b_in) |=> data_oe_out)
    else $error("reply bus not driven after read strobe");
  a_oe_released: assert property ($rose(read_strobe_b_in) |-> ##[1:2] !data_oe_out)
    else $error("reply bus still driven");
  a_pixel_pulse: assert property (pixel_valid_out |=> !pixel_valid_out)
    else $error("pixel valid longer than one cycle");
  a_pixel_source: assert property (pixel_valid_out |->
    $past(data_command_select_in) && pixel_data_out == $past(data_in))
    else $error("pixel byte differs from host byte");
  a_panel_on: assert property ($rose(write_strobe_b_in) && cmd_w && data_in == 8'h29
    |=> panel_on_out)
    else $error("panel not switched on");
  a_sleep_out: assert property ($rose(write_strobe_b_in) && cmd_w && data_in == 8'h11
    |=> awake_out)
    else $error("sleep-out not entered");
  a_sleep_in: assert property ($rose(write_strobe_b_in) && cmd_w && data_in == 8'h10
    |=> !awake_out)
    else $error("sleep-in not entered");
  a_restart_load: assert property ($rose(write_strobe_b_in) && cmd_w
    && data_in == 8'h01 |=> restart_busy_out && pixel_format_out == 3'h6
    && idle_colour_out == 3'h7 && !awake_out && !panel_on_out)
    else $error("soft restart defaults wrong");
  a_busy_refuses: assert property (restart_busy_out && $rose(write_strobe_b_in)
    && !data_command_select_in && data_in == 8'h29 |=> !panel_on_out)
    else $error("command accepted while busy");
  a_nop_quiet: assert property ($rose(write_strobe_b_in) && cmd_w && data_in == 8'h00
    |=> $stable(awake_out) && $stable(panel_on_out) && $stable(idle_colour_out))
    else $error("no-operation changed state");
endmodule // display_cmd_checker
bind display_command_decoder display_cmd_checker display_cmd_checker_i (.mclk_in(mclk_in),
  .rst_b_in(rst_b_in), .data_command_select_in(data_command_select_in),
  .write_strobe_b_in(write_strobe_b_in), .read_strobe_b_in(read_strobe_b_in),
  .data_in(data_in), .data_oe_out(data_oe_out), .pixel_data_out(pixel_data_out),
  .pixel_valid_out(pixel_valid_out), .panel_on_out(panel_on_out), .awake_out(awake_out),
  .restart_busy_out(restart_busy_out), .pixel_format_out(pixel_format_out),
  .idle_colour_out(idle_colour_out));

// ---- tb/host_bus_model.sv ----
/*
  Host processor model: command, parameter and read cycles on the
  parallel host pins. Assumes strobes idle high and the decoder's
  reply bus fed back to it.
*/
`timescale 1ns/100ps
module host_bus_model
(
  input wire mclk_in,
  input wire [7:0] dev_data_in,
  input wire dev_oe_in,
  output reg select_out,
  output reg write_strobe_b_out,
  output reg read_strobe_b_out,
  output wire [7:0] bus_out
);
  reg [7:0] drv_r;
  reg drive_r;
  // released bus shows the inverse of the last byte
  assign bus_out = dev_oe_in ? dev_data_in : (drive_r ? drv_r : ~drv_r);
  initial
  begin
    select_out = 1'b1;
    write_strobe_b_out = 1'b1;
    read_strobe_b_out = 1'b1;
    drv_r = 8'h00;
    drive_r = 1'b0;
  end
  // select low is a command byte, high a parameter or pixel byte
  task wr(input s, input [7:0] d);
  begin
    @(posedge mclk_in);
    #1;
    select_out = s;
    drv_r = d;
    drive_r = 1'b1;
    write_strobe_b_out = 1'b0;
    @(posedge mclk_in);
    #1;
    write_strobe_b_out = 1'b1;
    @(posedge mclk_in);
    @(posedge mclk_in);
    #1;
    drive_r = 1'b0;
  end
  endtask
  task rd(output [7:0] d);
  begin
    @(posedge mclk_in);
    #1;
    select_out = 1'b1;
    read_strobe_b_out = 1'b0;
    @(posedge mclk_in);
    @(posedge mclk_in);
    #1;
    d = dev_data_in;
    read_strobe_b_out = 1'b1;
    @(posedge mclk_in);
  end
  endtask
endmodule // host_bus_model

// ---- tb/tb.sv ----
/*
  Self-checking bench for the display command decoder.
  Assumes host_bus_model drives the host pins; short reload count.
*/
`timescale 1ns/100ps
module tb;
  reg mclk_in;
  reg rst_b_in;
  reg link_error_in;
  reg [3:0] sig_r;
  reg [2:0] diag_r;
  reg [8:0] line_r;
  integer n_fail;
  integer comparisons;
  integer cycles;
  reg [7:0] b;
  reg [7:0] pix_n;
  wire sel_w, ws_b_w, rs_b_w, oe_w, awake_w, panel_w, inv_w, idle_w, te_w, tm_w;
  wire pv_w, pf_w, busy_w;
  wire [7:0] din_w, dout_w, pd_w;
  wire [8:0] tl_w;
  wire [2:0] so_w, fmt_w, col_w;
  display_command_decoder #(.RESTART_CYCLES(20'd20)) display_command_decoder_i (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .data_command_select_in(sel_w),
    .write_strobe_b_in(ws_b_w), .read_strobe_b_in(rs_b_w), .data_in(din_w),
    .data_out(dout_w), .data_oe_out(oe_w), .link_error_in(link_error_in),
    .hsync_active_in(sig_r[3]), .vsync_active_in(sig_r[2]), .pixclk_active_in(sig_r[1]),
    .data_enable_active_in(sig_r[0]), .register_load_result_in(diag_r[2]),
    .function_check_result_in(diag_r[1]), .checksum_compare_result_in(diag_r[0]),
    .first_sum_in(8'hc3), .continued_sum_in(8'h3e), .scan_line_in(line_r),
    .awake_out(awake_w), .panel_on_out(panel_w), .polarity_flip_out(inv_w),
    .reduced_colour_out(idle_w), .tear_enable_out(te_w), .tear_mode_out(tm_w),
    .tear_line_out(tl_w), .scan_order_out(so_w), .pixel_format_out(fmt_w),
    .idle_colour_out(col_w), .pixel_data_out(pd_w), .pixel_valid_out(pv_w),
    .pixel_first_out(pf_w), .restart_busy_out(busy_w));
  host_bus_model host_bus_model_i (.mclk_in(mclk_in), .dev_data_in(dout_w),
    .dev_oe_in(oe_w), .select_out(sel_w), .write_strobe_b_out(ws_b_w),
    .read_strobe_b_out(rs_b_w), .bus_out(din_w));
  // pixel valid is a one-cycle pulse; count pulses so none is missed
  always @(posedge mclk_in)
    pix_n <= pix_n + pv_w;
  task give_verdict;
  begin
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  task chk(input [7:0] seen, input [7:0] exp);
  begin
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task w(input s, input [7:0] d);
    host_bus_model_i.wr(s, d);
  endtask
  task rdb(input [7:0] exp);
  begin
    host_bus_model_i.rd(b);
    chk(b, exp);
  end
  endtask
  task rdc(input [7:0] c, input [7:0] exp);
  begin
    w(1'b0, c);
    rdb(exp);
  end
  endtask
  task lerr(input integer n);
    repeat (n)
    begin
      @(posedge mclk_in);
      #1 link_error_in = 1'b1;
      @(posedge mclk_in);
      #1 link_error_in = 1'b0;
    end
  endtask
  task t_defaults;
  begin
    rdc(8'h0c, 8'h06);
    rdc(8'h91, 8'h07);
    rdc(8'h0a, 8'h00);
    rdc(8'h0b, 8'h00);
  end
  endtask
  task t_modes;
  begin
    w(1'b0, 8'h11);
    w(1'b0, 8'h29);
    w(1'b0, 8'h39);
    w(1'b0, 8'h21);
    chk({4'h0, awake_w, panel_w, idle_w, inv_w}, 8'h0f);
    w(1'b0, 8'h36);
    w(1'b1, 8'h1c);
    chk({5'h0, so_w}, 8'h07);
    w(1'b0, 8'h35);
    w(1'b1, 8'h01);
    chk({6'h0, te_w, tm_w}, 8'h03);
    rdc(8'h0a, 8'hd4);
    rdc(8'h0b, 8'h1c);
    w(1'b0, 8'h09);
    rdb(8'h8e);
    rdb(8'h6a);
    rdb(8'h26);
    rdb(8'h20);
    rdc(8'h0d, 8'h20);
    rdc(8'h0e, 8'he8);
    rdc(8'h0f, 8'h81);
  end
  endtask
  task t_params;
  begin
    w(1'b0, 8'h3a);
    w(1'b1, 8'h05);
    rdc(8'h0c, 8'h05);
    w(1'b0, 8'h44);
    w(1'b1, 8'h01);
    w(1'b1, 8'h23);
    w(1'b1, 8'hff);
    chk({7'h0, tl_w[8]}, 8'h01);
    chk(tl_w[7:0], 8'h23);
    w(1'b0, 8'h45);
    rdb(8'h01);
    rdb(8'ha5);
    w(1'b0, 8'h90);
    w(1'b1, 8'h03);
    w(1'b0, 8'h00);
    w(1'b0, 8'h77);
    w(1'b1, 8'h06);
    chk({2'h0, fmt_w, col_w}, 8'h2b);
    rdc(8'h91, 8'h03);
    w(1'b0, 8'h04);
    rdb(8'h5a);
    rdb(8'h01);
    rdb(8'h3c);
    rdc(8'hda, 8'h5a);
    rdc(8'hdb, 8'h01);
    rdc(8'hdc, 8'h3c);
    rdc(8'haa, 8'hc3);
    rdc(8'haf, 8'h3e);
  end
  endtask
  task t_pixels;
  begin
    w(1'b0, 8'h2c);
    w(1'b1, 8'ha1);
    chk({pix_n[6:0], pf_w}, 8'h03);
    chk(pd_w, 8'ha1);
    w(1'b1, 8'hb2);
    chk({pix_n[6:0], pf_w}, 8'h04);
    w(1'b0, 8'h3c);
    w(1'b1, 8'hc3);
    chk({pix_n[6:0], pf_w}, 8'h06);
    chk(pd_w, 8'hc3);
  end
  endtask
  task t_off;
  begin
    w(1'b0, 8'h20);
    w(1'b0, 8'h28);
    w(1'b0, 8'h38);
    w(1'b0, 8'h34);
    w(1'b0, 8'h10);
    rdc(8'h0a, 8'h00);
    chk({4'h0, awake_w, panel_w, idle_w, inv_w}, 8'h00);
    rdc(8'h0d, 8'h00);
    chk({7'h0, te_w}, 8'h00);
  end
  endtask
  task t_errors;
  begin
    lerr(3);
    rdc(8'h0e, 8'h69);
    rdc(8'h05, 8'h03);
    rdc(8'h05, 8'h00);
    lerr(130);
    rdc(8'h05, 8'hff);
  end
  endtask
  task t_restart;
    integer k;
  begin
    w(1'b0, 8'h11);
    w(1'b0, 8'h29);
    w(1'b0, 8'h01);
    chk({busy_w, awake_w, panel_w, fmt_w, 2'h0}, 8'h98);
    w(1'b0, 8'h29);
    chk({7'h0, panel_w}, 8'h00);
    // the host waits out the reload interval before its next command
    for (k = 0; k < 100 && busy_w !== 1'b0; k = k + 1)
    begin
      @(posedge mclk_in);
      #1;
    end
    chk({7'h0, busy_w}, 8'h00);
    w(1'b0, 8'h29);
    chk({7'h0, panel_w}, 8'h01);
    chk({col_w, so_w, 2'h0}, 8'he0);
  end
  endtask
  initial
  begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      n_fail = n_fail + 1;
      give_verdict;
    end
  end
  initial
  begin
    n_fail = 0;
    comparisons = 0;
    cycles = 0;
    pix_n = 8'h00;
    rst_b_in = 1'b0;
    link_error_in = 1'b0;
    sig_r = 4'ha;
    diag_r = 3'h5;
    line_r = 9'h1a5;
    repeat (12) @(posedge mclk_in);
    #1 rst_b_in = 1'b1;
    repeat (2) @(posedge mclk_in);
    t_defaults;
    t_modes;
    t_params;
    t_pixels;
    t_off;
    t_errors;
    t_restart;
    give_verdict;
  end
endmodule // tb
